// File: verilog/nas_pkg.sv
// Package for the network address select and owner lock block.
// Assumes a single 100 MHz clock domain; all users write nas_pkg::name.
package nas_pkg;

  // Fixed recovery identity and static mask
  localparam logic [31:0] RECOVERY_IP = 32'h0a0a0a0a;
  localparam logic [31:0] RECOVERY_MASK = 32'hff000000;
  localparam logic [31:0] STATIC_MASK = 32'hffff0000;

  // Factory defaults for the static switch positions
  localparam logic [31:0] NET_LOW = 32'hc0a80100;
  localparam logic [31:0] NET_HIGH = 32'hc0a80000;
  localparam logic [3:0] LAST_LOW_POS = 4'h3;
  localparam logic [7:0] HOST_STEP = 8'h0a;

  // Switch positions with special meaning
  localparam logic [3:0] RECOVERY_POS = 4'h0;
  localparam logic [3:0] DHCP_POS = 4'hf;
  localparam int SWITCH_POSITIONS = 16;

  // Command ports
  localparam logic [15:0] UDP_CMD_PORT = 16'h1e5f;
  localparam logic [15:0] TCP_CMD_PORT = 16'h1e60;

  // Command payload framing
  localparam logic [7:0] HDR_BYTE0 = 8'h00;
  localparam logic [7:0] HDR_BYTE1 = 8'h07;
  localparam logic [7:0] TERM_BYTE = 8'h0d;
  localparam logic [7:0] PRINT_LO = 8'h20;
  localparam logic [7:0] PRINT_HI = 8'h7e;

  // Switch settle time after reset release
  localparam int SETTLE_NS = 80;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [3:0] SETTLE_CYCLES = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic sof;
    logic valid;
    logic last;
    logic [7:0] data;
  } nas_byte_s;

  typedef struct packed {
    logic tcp;
    logic [15:0] dst_port;
    logic [31:0] src_ip;
    logic [15:0] src_port;
  } nas_meta_s;

  typedef struct packed {
    logic [31:0] ip;
    logic [15:0] port;
  } nas_peer_s;

  function automatic logic [31:0] nas_default_ip(input logic [3:0] pos);
    logic [7:0] host;
    host = 8'(pos * HOST_STEP);
    if (pos == RECOVERY_POS)
      nas_default_ip = RECOVERY_IP;
    else if (pos <= LAST_LOW_POS)
      nas_default_ip = NET_LOW | {24'h000000, host};
    else
      nas_default_ip = NET_HIGH | {24'h000000, host};
  endfunction

  function automatic logic [31:0] nas_mask_for(input logic [3:0] pos);
    nas_mask_for = (pos == RECOVERY_POS) ? RECOVERY_MASK : STATIC_MASK;
  endfunction

  function automatic logic nas_printable(input logic [7:0] b);
    nas_printable = (b >= PRINT_LO) && (b <= PRINT_HI);
  endfunction

endpackage

// File: verilog/nas_addr_table.sv
// Table of static addresses, one word per switch position, read data registered.
// Assumes writes come from same-clock configuration logic.
`timescale 1ns/1ps
`default_nettype none
module nas_addr_table #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int W = 32,
  parameter logic [3:0] LOCKED_IDX = 4'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [W-1:0] next_rd_data;

  always_comb
  begin
    next_mem = mem;
    next_rd_data = rd_data;
    // The recovery entry is never written so it always stays reachable
    if (wr_en && wr_idx != AW'(LOCKED_IDX))
      next_mem[wr_idx] = wr_data;
    if (rd_en)
      next_rd_data = mem[rd_idx];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= W'(nas_pkg::nas_default_ip(4'(i)));
      rd_data <= '0;
    end
    else
    begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule
`default_nettype wire

// File: verilog/nas_frame_check.sv
// Checks one command payload: two header bytes, printable text, carriage return.
// Assumes one payload at a time; sof marks its first byte, last its final one.
`timescale 1ns/1ps
`default_nettype none
module nas_frame_check (
  input wire logic clk,
  input wire logic rst,
  input wire nas_pkg::nas_byte_s in_byte,
  output nas_pkg::nas_byte_s out_char,
  output logic end_ok,
  output logic end_bad
);
  logic [1:0] pos;
  logic bad;
  logic seen;
  logic [1:0] next_pos;
  logic next_bad;
  logic next_seen;
  nas_pkg::nas_byte_s next_out_char;
  logic next_end_ok;
  logic next_end_bad;

  always_comb
  begin
    logic [1:0] p;
    logic b;
    logic s;
    p = in_byte.sof ? 2'h0 : pos;
    b = in_byte.sof ? 1'b0 : bad;
    s = in_byte.sof ? 1'b0 : seen;
    next_pos = pos;
    next_bad = bad;
    next_seen = seen;
    next_out_char = '0;
    next_end_ok = 1'b0;
    next_end_bad = 1'b0;
    if (in_byte.valid)
    begin
      unique case (p)
        2'h0: b = b | (in_byte.data != nas_pkg::HDR_BYTE0);
        2'h1: b = b | (in_byte.data != nas_pkg::HDR_BYTE1);
        default:
          b = b | (in_byte.last ? (in_byte.data != nas_pkg::TERM_BYTE)
                                : !nas_pkg::nas_printable(in_byte.data));
      endcase
      // Characters go out as they pass; the parser discards them on end_bad
      if (p == 2'h2 && !in_byte.last && !b)
      begin
        next_out_char.valid = 1'b1;
        next_out_char.sof = !s;
        next_out_char.data = in_byte.data;
        s = 1'b1;
      end
      next_pos = (p == 2'h2) ? p : p + 2'h1;
      next_bad = b;
      next_seen = s;
      if (in_byte.last)
      begin
        next_end_ok = !b && p == 2'h2;
        next_end_bad = !(!b && p == 2'h2);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos <= 2'h0;
      bad <= 1'b0;
      seen <= 1'b0;
      out_char <= '0;
      end_ok <= 1'b0;
      end_bad <= 1'b0;
    end
    else
    begin
      pos <= next_pos;
      bad <= next_bad;
      seen <= next_seen;
      out_char <= next_out_char;
      end_ok <= next_end_ok;
      end_bad <= next_end_bad;
    end
  end
endmodule
`default_nettype wire

// File: verilog/nas_owner_lock.sv
// Network identity select and command ownership lock for a drive's Ethernet port.
// Assumes the switch is a raw pin, packet bytes and metadata come from same-clock
// stack logic, and rst is only asserted at power-up.
`timescale 1ns/1ps
`default_nettype none
module nas_owner_lock #(
  parameter int TABLE_DEPTH = nas_pkg::SWITCH_POSITIONS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] switch_pos,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_index,
  input wire logic [31:0] cfg_ip,
  input wire logic dhcp_valid,
  input wire logic [31:0] dhcp_ip,
  input wire logic [31:0] dhcp_mask,
  input wire nas_pkg::nas_byte_s rx_byte,
  input wire nas_pkg::nas_meta_s rx_meta,
  output logic [31:0] local_ip,
  output logic [31:0] local_mask,
  output logic ip_ready,
  output logic dhcp_request,
  output logic [3:0] sel_pos,
  output nas_pkg::nas_byte_s cmd_char,
  output logic cmd_ok,
  output logic cmd_bad,
  output logic cmd_tcp,
  output logic refused,
  output logic owned,
  output nas_pkg::nas_peer_s owner,
  output logic resp_tcp
);
  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_READ,
    ST_APPLY,
    ST_DHCP,
    ST_READY
  } nas_addr_e;

  // Switch synchroniser
  logic [3:0] sw_meta;
  logic [3:0] sw_sync;

  // Address selection state
  nas_addr_e state;
  nas_addr_e next_state;
  logic [3:0] settle_cnt;
  logic [3:0] next_settle_cnt;
  logic [3:0] next_sel_pos;
  logic [31:0] next_local_ip;
  logic [31:0] next_local_mask;
  logic next_ip_ready;
  logic next_dhcp_request;
  logic tbl_rd;
  logic [31:0] tbl_q;

  // Command filter state
  logic pass;
  logic next_pass;
  nas_pkg::nas_meta_s pkt_meta;
  nas_pkg::nas_meta_s next_pkt_meta;
  logic next_owned;
  nas_pkg::nas_peer_s next_owner;
  logic next_resp_tcp;
  logic next_refused;
  nas_pkg::nas_byte_s next_cmd_char;
  logic next_cmd_ok;
  logic next_cmd_bad;
  logic next_cmd_tcp;
  nas_pkg::nas_byte_s gated;
  nas_pkg::nas_byte_s chk_char;
  logic chk_ok;
  logic chk_bad;
  logic port_hit;
  logic lock_live;
  logic [31:0] lock_ip;
  logic admit;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sw_meta <= 4'h0;
      sw_sync <= 4'h0;
    end
    else
    begin
      sw_meta <= switch_pos;
      sw_sync <= sw_meta;
    end
  end

  nas_addr_table #(
    .DEPTH(TABLE_DEPTH),
    .AW(4),
    .W(32),
    .LOCKED_IDX(nas_pkg::RECOVERY_POS)
  ) u_table (
    .clk(mclk),
    .rst(rst),
    .wr_en(cfg_wr),
    .wr_idx(cfg_index),
    .wr_data(cfg_ip),
    .rd_en(tbl_rd),
    .rd_idx(sel_pos),
    .rd_data(tbl_q)
  );

  // The switch is sampled once after power-up; later turns take effect on next power cycle
  always_comb
  begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    next_sel_pos = sel_pos;
    next_local_ip = local_ip;
    next_local_mask = local_mask;
    next_ip_ready = ip_ready;
    next_dhcp_request = dhcp_request;
    tbl_rd = 1'b0;
    unique case (state)
      ST_SETTLE:
      begin
        next_settle_cnt = settle_cnt + 4'h1;
        if (settle_cnt == nas_pkg::SETTLE_CYCLES)
        begin
          next_sel_pos = sw_sync;
          if (sw_sync == nas_pkg::DHCP_POS)
          begin
            next_dhcp_request = 1'b1;
            next_state = ST_DHCP;
          end
          else
            next_state = ST_READ;
        end
      end
      ST_READ:
      begin
        tbl_rd = 1'b1;
        next_state = ST_APPLY;
      end
      ST_APPLY:
      begin
        if (sel_pos == nas_pkg::RECOVERY_POS)
          next_local_ip = nas_pkg::RECOVERY_IP;
        else
          next_local_ip = tbl_q;
        next_local_mask = nas_pkg::nas_mask_for(sel_pos);
        next_ip_ready = 1'b1;
        next_state = ST_READY;
      end
      ST_DHCP:
      begin
        if (dhcp_valid)
        begin
          next_local_ip = dhcp_ip;
          next_local_mask = dhcp_mask;
          next_ip_ready = 1'b1;
          next_dhcp_request = 1'b0;
          next_state = ST_READY;
        end
      end
      ST_READY:
      begin
        // A rewrite of the active entry at positions 1 to 14 is reloaded through ST_READ and ST_APPLY, without a power cycle
        if (cfg_wr && cfg_index == sel_pos && sel_pos != nas_pkg::RECOVERY_POS
            && sel_pos != nas_pkg::DHCP_POS)
          next_state = ST_READ;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_SETTLE;
      settle_cnt <= 4'h0;
      sel_pos <= 4'h0;
      local_ip <= 32'h00000000;
      local_mask <= 32'h00000000;
      ip_ready <= 1'b0;
      dhcp_request <= 1'b0;
    end
    else
    begin
      state <= next_state;
      settle_cnt <= next_settle_cnt;
      sel_pos <= next_sel_pos;
      local_ip <= next_local_ip;
      local_mask <= next_local_mask;
      ip_ready <= next_ip_ready;
      dhcp_request <= next_dhcp_request;
    end
  end

  // Only traffic for the two command ports is looked at; other traffic passes by untouched
  assign port_hit = (!rx_meta.tcp && rx_meta.dst_port == nas_pkg::UDP_CMD_PORT)
                 || (rx_meta.tcp && rx_meta.dst_port == nas_pkg::TCP_CMD_PORT);
  // A claim still in flight locks too, so a second sender cannot slip in behind it
  assign lock_live = owned || chk_ok;
  assign lock_ip = owned ? owner.ip : pkt_meta.src_ip;
  assign admit = port_hit && ip_ready && (!lock_live || rx_meta.src_ip == lock_ip);

  always_comb
  begin
    gated = rx_byte;
    gated.valid = rx_byte.valid && (rx_byte.sof ? admit : pass);
  end

  // Same checker for both transports, so both see one command format
  nas_frame_check u_check (
    .clk(mclk),
    .rst(rst),
    .in_byte(gated),
    .out_char(chk_char),
    .end_ok(chk_ok),
    .end_bad(chk_bad)
  );

  always_comb
  begin
    next_pass = pass;
    next_pkt_meta = pkt_meta;
    next_owned = owned;
    next_owner = owner;
    next_resp_tcp = resp_tcp;
    next_refused = 1'b0;
    next_cmd_char = chk_char;
    next_cmd_ok = chk_ok;
    next_cmd_bad = chk_bad;
    next_cmd_tcp = cmd_tcp;
    if (rx_byte.valid && rx_byte.sof)
    begin
      next_pass = admit && !rx_byte.last;
      next_refused = port_hit && ip_ready && !admit;
      if (admit)
      begin
        next_pkt_meta = rx_meta;
        next_cmd_tcp = rx_meta.tcp;
      end
    end
    else if (rx_byte.valid && rx_byte.last)
      next_pass = 1'b0;
    if (chk_ok)
    begin
      next_resp_tcp = pkt_meta.tcp;
      // The record is written once and never again while powered
      if (!owned)
      begin
        next_owned = 1'b1;
        next_owner.ip = pkt_meta.src_ip;
        next_owner.port = pkt_meta.src_port;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pass <= 1'b0;
      pkt_meta <= '0;
      owned <= 1'b0;
      owner <= '0;
      resp_tcp <= 1'b0;
      refused <= 1'b0;
      cmd_char <= '0;
      cmd_ok <= 1'b0;
      cmd_bad <= 1'b0;
      cmd_tcp <= 1'b0;
    end
    else
    begin
      pass <= next_pass;
      pkt_meta <= next_pkt_meta;
      owned <= next_owned;
      owner <= next_owner;
      resp_tcp <= next_resp_tcp;
      refused <= next_refused;
      cmd_char <= next_cmd_char;
      cmd_ok <= next_cmd_ok;
      cmd_bad <= next_cmd_bad;
      cmd_tcp <= next_cmd_tcp;
    end
  end
endmodule
`default_nettype wire

// File: testbench/nas_owner_lock_sva.sv
// Checker for the address select and owner lock block, bound to its ports.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/1ps
`default_nettype none
module nas_owner_lock_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] sel_pos,
  input wire logic ip_ready,
  input wire logic [31:0] local_ip,
  input wire logic [31:0] local_mask,
  input wire logic dhcp_request,
  input wire logic dhcp_valid,
  input wire logic [31:0] dhcp_ip,
  input wire logic [31:0] dhcp_mask,
  input wire nas_pkg::nas_byte_s rx_byte,
  input wire nas_pkg::nas_meta_s rx_meta,
  input wire logic cmd_ok,
  input wire logic cmd_bad,
  input wire logic refused,
  input wire logic owned,
  input wire nas_pkg::nas_peer_s owner
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic port_hit;
  assign port_hit = (!rx_meta.tcp && rx_meta.dst_port == 16'h1e5f) ||
    (rx_meta.tcp && rx_meta.dst_port == 16'h1e60);
  a_recovery_addr: assert property (ip_ready && sel_pos == 4'h0 |->
    local_ip == 32'h0a0a0a0a && local_mask == 32'hff000000)
    else $error("recovery address or mask wrong");
  a_static_mask: assert property (ip_ready && sel_pos != 4'h0 && sel_pos != 4'hf |->
    local_mask == 32'hffff0000)
    else $error("static mask wrong");
  a_ready_holds: assert property (ip_ready |=> ip_ready && $stable(local_mask))
    else $error("applied identity dropped");
  a_dhcp_start: assert property ($rose(dhcp_request) |-> sel_pos == 4'hf && !ip_ready)
    else $error("address request without position F");
  a_dhcp_done: assert property (dhcp_request && dhcp_valid |=>
    ip_ready && !dhcp_request &&
    local_ip == $past(dhcp_ip) && local_mask == $past(dhcp_mask))
    else $error("server address not applied");
  a_owner_keep: assert property (owned |=> owned && $stable(owner))
    else $error("owner record changed");
  a_claim_good: assert property ($rose(owned) |-> cmd_ok)
    else $error("owner claimed without good command");
  a_refuse_cause: assert property (refused |->
    $past(rx_byte.valid && rx_byte.sof && port_hit))
    else $error("refusal without command-port packet");
  a_owner_pass: assert property (rx_byte.valid && rx_byte.sof && owned && ip_ready &&
    rx_meta.src_ip == owner.ip |=> !refused)
    else $error("owner packet refused");
  a_end_excl: assert property (!(cmd_ok && cmd_bad))
    else $error("good and bad end together");
endmodule
bind nas_owner_lock nas_owner_lock_sva u_sva (.mclk(mclk), .rst(rst), .sel_pos(sel_pos),
  .ip_ready(ip_ready), .local_ip(local_ip), .local_mask(local_mask),
  .dhcp_request(dhcp_request), .dhcp_valid(dhcp_valid), .dhcp_ip(dhcp_ip),
  .dhcp_mask(dhcp_mask), .rx_byte(rx_byte), .rx_meta(rx_meta), .cmd_ok(cmd_ok),
  .cmd_bad(cmd_bad), .refused(refused), .owned(owned), .owner(owner));
`default_nettype wire

// File: testbench/nas_host_model.sv
// Host model: streams command payloads with their packet metadata.
// Assumes the bench calls send per payload and idle after a burst.
`timescale 1ns/1ps
`default_nettype none
module nas_host_model (
  input wire logic mclk,
  output var nas_pkg::nas_byte_s rx_byte,
  output var nas_pkg::nas_meta_s rx_meta
);
  initial
  begin
    rx_byte = '0;
    rx_meta = '0;
  end
  // Released lines show inverted values so stale bytes never pass for fresh ones
  task automatic idle();
    @(posedge mclk);
    #1;
    rx_byte = '{sof: 1'b0, valid: 1'b0, last: 1'b0, data: ~rx_byte.data};
  endtask
  task automatic send(input logic [31:0] ip, input logic [15:0] sp, input logic [15:0] dp,
    input logic tcp, input logic [7:0] q[$]);
    foreach (q[i])
    begin
      @(posedge mclk);
      #1;
      rx_byte = '{sof: i == 0, valid: 1'b1, last: i == q.size() - 1, data: q[i]};
      if (i == 0)
        rx_meta = '{tcp: tcp, dst_port: dp, src_ip: ip, src_port: sp};
      else
        rx_meta = ~rx_meta;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the address select and owner lock block.
// Assumes the host model drives packets; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, rst = 1, cfg_wr = 0, dhcp_valid = 0;
  logic [3:0] switch_pos = 0, cfg_index = 0, sel_pos;
  logic [31:0] cfg_ip = 0, dhcp_ip = 0, dhcp_mask = 0, local_ip, local_mask, ipa, ipb;
  logic ip_ready, dhcp_request, cmd_ok, cmd_bad, cmd_tcp, refused, owned, resp_tcp;
  nas_pkg::nas_byte_s rx_byte, cmd_char;
  nas_pkg::nas_meta_s rx_meta;
  nas_pkg::nas_peer_s owner;
  int num_errors = 0, comparisons = 0, seed = 77904, n_ok = 0, n_bad = 0, n_ref = 0, n_sof = 0;
  logic [7:0] got_q[$], exp_q[$], pk[$];
  nas_owner_lock u_dut (.mclk(mclk), .rst(rst), .switch_pos(switch_pos), .cfg_wr(cfg_wr),
    .cfg_index(cfg_index), .cfg_ip(cfg_ip), .dhcp_valid(dhcp_valid), .dhcp_ip(dhcp_ip),
    .dhcp_mask(dhcp_mask), .rx_byte(rx_byte), .rx_meta(rx_meta), .local_ip(local_ip),
    .local_mask(local_mask), .ip_ready(ip_ready), .dhcp_request(dhcp_request),
    .sel_pos(sel_pos), .cmd_char(cmd_char), .cmd_ok(cmd_ok), .cmd_bad(cmd_bad),
    .cmd_tcp(cmd_tcp), .refused(refused), .owned(owned), .owner(owner), .resp_tcp(resp_tcp));
  nas_host_model u_host (.mclk(mclk), .rx_byte(rx_byte), .rx_meta(rx_meta));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // Sampled mid-cycle so every one-cycle pulse is seen settled, exactly once
  always @(negedge mclk)
  begin
    if (cmd_char.valid === 1'b1)
      got_q.push_back(cmd_char.data);
    n_sof += int'(cmd_char.valid === 1'b1 && cmd_char.sof === 1'b1);
    n_ok += int'(cmd_ok === 1'b1);
    n_bad += int'(cmd_bad === 1'b1);
    n_ref += int'(refused === 1'b1);
  end
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Reference address table, kept apart from the design's own helpers
  function automatic logic [31:0] exp_ip(input int p);
    if (p == 0)
      return 32'h0a0a0a0a;
    return (p < 4 ? 32'hc0a80100 : 32'hc0a80000) + 32'(p * 10);
  endfunction
  task automatic do_reset(input int n, input logic [3:0] p);
    rst = 1;
    switch_pos = p;
    cyc(n);
    rst = 0;
    chk({ip_ready, dhcp_request, owned, local_ip}, 35'h0);
    for (int i = 0; i < 40 && ip_ready !== 1'b1 && dhcp_request !== 1'b1; i++)
      cyc(1);
    if (ip_ready !== 1'b1 && dhcp_request !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic run(input logic [31:0] ip, input logic [15:0] sp, input logic [15:0] dp,
    input logic tcp, input logic [7:0] h1, input int good, input int nchar);
    pk = {8'h00, h1};
    for (int i = 0; i < nchar; i++)
    begin
      pk.push_back(8'h20 + 8'($unsigned($random(seed)) % 95));
      if (good != 0)
        exp_q.push_back(pk[$]);
    end
    pk.push_back(8'h0d);
    u_host.send(ip, sp, dp, tcp, pk);
  endtask
  // Text is compared only after the stream has drained
  task automatic flush(input int e_ok, input int e_bad, input int e_ref);
    u_host.idle();
    cyc(5);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i])
      chk(got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
    chk({n_ok, n_bad, n_ref}, {e_ok, e_bad, e_ref});
    chk(n_sof, e_ok);
  endtask
  initial
  begin
    for (int p = 0; p < 16; p++)
    begin
      do_reset(p == 0 ? 16 : 3, 4'(p));
      switch_pos = 4'($random(seed));
      chk(sel_pos, p);
      if (p == 15)
      begin
        chk({ip_ready, dhcp_request}, 2'b01);
        dhcp_ip = $random(seed);
        dhcp_mask = $random(seed);
        dhcp_valid = 1;
        cyc(1);
        dhcp_valid = 0;
        cyc(1);
        chk({ip_ready, dhcp_request, local_ip, local_mask},
          {2'b10, dhcp_ip, dhcp_mask});
      end
      else
        chk({local_ip, local_mask},
          {exp_ip(p), p == 0 ? 32'hff000000 : 32'hffff0000});
      // A write to the active entry reloads it, except for recovery and server modes
      cfg_index = 4'(p);
      cfg_ip = $random(seed);
      cfg_wr = 1;
      cyc(1);
      cfg_wr = 0;
      cyc(3);
      chk(local_ip,
        p == 0 ? 32'h0a0a0a0a : (p == 15 ? dhcp_ip : cfg_ip));
      chk(sel_pos, p);
    end
    ipa = $random(seed);
    ipb = ipa ^ 32'h1;
    run(ipa, 16'h1000, 16'h1e5f, 0, 8'h06, 0, 0);
    flush(0, 1, 0);
    chk(owned, 1'b0);
    run(ipa, 16'h1001, 16'h1e61, 0, 8'h07, 0, 2);
    flush(0, 1, 0);
    run(ipa, 16'h1000, 16'h1e5f, 0, 8'h07, 1, 3);
    flush(1, 1, 0);
    chk({owned, owner, resp_tcp}, {1'b1, ipa, 16'h1000, 1'b0});
    chk(cmd_tcp, 1'b0);
    run(ipb, 16'h2000, 16'h1e60, 1, 8'h07, 0, 2);
    run(ipa, 16'h3000, 16'h1e60, 1, 8'h07, 1, 4);
    flush(2, 1, 1);
    chk({owner, resp_tcp, cmd_tcp}, {ipa, 16'h1000, 2'b11});
    run(ipb, 16'h1000, 16'h1e5f, 0, 8'h07, 0, 1);
    flush(2, 1, 2);
    chk({owned, owner}, {1'b1, ipa, 16'h1000});
    give_verdict();
  end
endmodule
`default_nettype wire
